// >>> design/jpd_dev.sv
`include "jpd_params.svh"
`default_nettype none
module jpd_dev #(
    parameter int TMO_SHORT_CYC = (`JPD_TMO_SHORT_NS + `JPD_MCLK_PERIOD_NS - 1) / `JPD_MCLK_PERIOD_NS,
    parameter int TMO_LONG_CYC = (`JPD_TMO_LONG_NS + `JPD_MCLK_PERIOD_NS - 1) / `JPD_MCLK_PERIOD_NS
) (
    jpd_link_if.dev lnk,
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_opt,
    output logic core_rst_n,
    output logic prog_enabled,
    output logic cmd_stb,
    output logic [`JPD_CMD_W-1:0] cmd_word,
    input wire logic res_valid,
    input wire logic [`JPD_CMD_W-1:0] res_data,
    output logic rd_req,
    output logic [15:0] rd_addr,
    output logic rd_hi,
    input wire logic rd_ack,
    input wire logic [`JPD_BYTE_W-1:0] rd_data
);
    import jpd_pkg::*;

    localparam int CW = $clog2(TMO_LONG_CYC + 1);

    // Link clock domain
    jpd_tap_t tap;
    logic [`JPD_IR_W-1:0] ir_q;
    logic [`JPD_IR_W-1:0] ir_sh_q;
    logic [15:0] dr_q;
    logic [15:0] dr_shifted;
    logic rst_q;
    logic [`JPD_KEY_W-1:0] key_q;
    logic [`JPD_CMD_W-1:0] cmd_q;
    logic cmd_tgl_q;
    logic [15:0] pc_q;
    logic hi_q;
    logic fe_tgl_q;
    logic [`JPD_BYTE_W-1:0] fbyte_q;
    logic [`JPD_CMD_W-1:0] res_tck_q;
    logic rs1_q, rs2_q, rs3_q;
    logic fa1_q, fa2_q, fa3_q;
    logic tdo_q;
    logic oe_q;

    // Main clock domain
    logic [`JPD_CMD_W-1:0] res_q;
    logic res_tgl_q;
    logic [`JPD_BYTE_W-1:0] fdat_q;
    logic fa_tgl_q;
    logic c1_q, c2_q, c3_q;
    logic f1_q, f2_q, f3_q;
    logic r1_q, r2_q, r3_q;
    logic e1_q, e2_q;
    logic [CW-1:0] tmo_q;
    logic cmd_stb_q;
    logic [`JPD_CMD_W-1:0] cmd_word_q;
    logic rd_req_q;
    logic [15:0] rd_addr_q;
    logic rd_hi_q;

    jpd_tap u_tap (
        .tck(lnk.tck),
        .nrst(nrst),
        .tms(lnk.tms),
        .state(tap)
    );

    wire sel_rst = (ir_q == `JPD_IR_CORE_RESET);
    wire sel_key = (ir_q == `JPD_IR_KEY);
    wire sel_cmd = (ir_q == `JPD_IR_CMD);
    wire sel_pr = (ir_q == `JPD_IR_PAGE_READ);
    wire enabled = (key_q == `JPD_KEY_VALUE);
    wire [4:0] dr_len = sel_key ? `JPD_LEN_KEY : sel_cmd ? `JPD_LEN_CMD :
                        sel_pr ? `JPD_LEN_BYTE : `JPD_LEN_RST;
    wire upd_cmd = (tap == TAP_UPD_DR) && sel_cmd && enabled;
    wire [`JPD_CMD_W-1:0] new_cmd = dr_q[`JPD_CMD_W-1:0];
    wire new_lo = (new_cmd[`JPD_CMD_W-1:`JPD_OP_LSB] == `JPD_OP_ADDR_LO);
    wire new_hi = (new_cmd[`JPD_CMD_W-1:`JPD_OP_LSB] == `JPD_OP_ADDR_HI);
    wire pr_cap = (tap == TAP_CAP_DR) && sel_pr && enabled;
    wire pr_start = (tap == TAP_UPD_IR) && (ir_sh_q == `JPD_IR_PAGE_READ) && enabled;

    // Serial input enters at the top bit of the selected length
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (5'(i) == dr_len - 5'h01) begin
                dr_shifted[i] = lnk.tdi;
            end else if (i < 15) begin
                dr_shifted[i] = dr_q[i+1];
            end else begin
                dr_shifted[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            ir_q <= `JPD_IR_BYPASS;
            ir_sh_q <= `JPD_IR_BYPASS;
        end else if (tap == TAP_TLR) begin
            ir_q <= `JPD_IR_BYPASS;
        end else if (tap == TAP_CAP_IR) begin
            ir_sh_q <= `JPD_IR_CAPTURE;
        end else if (tap == TAP_SHIFT_IR) begin
            ir_sh_q <= {lnk.tdi, ir_sh_q[`JPD_IR_W-1:1]};
        end else if (tap == TAP_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    always_ff @(posedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            dr_q <= 16'h0000;
        end else if (tap == TAP_CAP_DR) begin
            if (sel_cmd) begin
                dr_q <= {1'b0, res_tck_q};
            end else if (pr_cap) begin
                dr_q <= {8'h00, fbyte_q};
            end else begin
                dr_q <= sel_key ? key_q : 16'h0000;
            end
        end else if (tap == TAP_SHIFT_DR && !sel_rst) begin
            dr_q <= dr_shifted;
        end
    end

    // No update stage: the core sees every shifted bit at once
    always_ff @(posedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 1'b0;
        end else if (tap == TAP_SHIFT_DR && sel_rst) begin
            rst_q <= lnk.tdi;
        end
    end

    always_ff @(posedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            key_q <= `JPD_KEY_RESET;
            cmd_q <= `JPD_NOP_CMD;
            cmd_tgl_q <= 1'b0;
        end else if (tap == TAP_UPD_DR && sel_key) begin
            key_q <= dr_q;
        end else if (upd_cmd) begin
            cmd_q <= new_cmd;
            cmd_tgl_q <= ~cmd_tgl_q;
        end
    end

    // Prefetch keeps the next byte ready before the next capture
    always_ff @(posedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            pc_q <= 16'h0000;
            hi_q <= 1'b0;
            fe_tgl_q <= 1'b0;
        end else if (upd_cmd && (new_lo || new_hi)) begin
            pc_q <= new_lo ? {pc_q[15:8], new_cmd[7:0]} : {new_cmd[7:0], pc_q[7:0]};
            hi_q <= 1'b0;
        end else if (pr_start) begin
            fe_tgl_q <= ~fe_tgl_q;
        end else if (pr_cap) begin
            if (hi_q) begin
                pc_q <= pc_q + 16'h0001;
            end
            hi_q <= ~hi_q;
            fe_tgl_q <= ~fe_tgl_q;
        end
    end

    always_ff @(posedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
            rs3_q <= 1'b0;
            fa1_q <= 1'b0;
            fa2_q <= 1'b0;
            fa3_q <= 1'b0;
            res_tck_q <= `JPD_NOP_CMD;
            fbyte_q <= 8'h00;
        end else begin
            rs1_q <= res_tgl_q;
            rs2_q <= rs1_q;
            rs3_q <= rs2_q;
            fa1_q <= fa_tgl_q;
            fa2_q <= fa1_q;
            fa3_q <= fa2_q;
            if (rs2_q != rs3_q) begin
                res_tck_q <= res_q;
            end
            if (fa2_q != fa3_q) begin
                fbyte_q <= fdat_q;
            end
        end
    end

    always_ff @(negedge lnk.tck or negedge nrst) begin
        if (!nrst) begin
            tdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            tdo_q <= (tap == TAP_SHIFT_IR) ? ir_sh_q[0] : (sel_rst ? rst_q : dr_q[0]);
            oe_q <= (tap == TAP_SHIFT_IR) || (tap == TAP_SHIFT_DR);
        end
    end

    assign lnk.tdo = tdo_q;
    assign lnk.tdo_oe = oe_q;

    // Main clock side of the crossings
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            c1_q <= 1'b0;
            c2_q <= 1'b0;
            c3_q <= 1'b0;
            f1_q <= 1'b0;
            f2_q <= 1'b0;
            f3_q <= 1'b0;
            e1_q <= 1'b0;
            e2_q <= 1'b0;
            cmd_stb_q <= 1'b0;
            cmd_word_q <= `JPD_NOP_CMD;
            rd_req_q <= 1'b0;
            rd_addr_q <= 16'h0000;
            rd_hi_q <= 1'b0;
        end else begin
            c1_q <= cmd_tgl_q;
            c2_q <= c1_q;
            c3_q <= c2_q;
            f1_q <= fe_tgl_q;
            f2_q <= f1_q;
            f3_q <= f2_q;
            e1_q <= enabled;
            e2_q <= e1_q;
            cmd_stb_q <= c2_q ^ c3_q;
            rd_req_q <= f2_q ^ f3_q;
            if (c2_q != c3_q) begin
                cmd_word_q <= cmd_q;
            end
            if (f2_q != f3_q) begin
                rd_addr_q <= pc_q;
                rd_hi_q <= hi_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_q <= `JPD_NOP_CMD;
            res_tgl_q <= 1'b0;
            fdat_q <= 8'h00;
            fa_tgl_q <= 1'b0;
        end else begin
            if (res_valid) begin
                res_q <= res_data;
                res_tgl_q <= ~res_tgl_q;
            end
            if (rd_ack) begin
                fdat_q <= rd_data;
                fa_tgl_q <= ~fa_tgl_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r1_q <= 1'b0;
            r2_q <= 1'b0;
            r3_q <= 1'b0;
            tmo_q <= '0;
        end else begin
            r1_q <= rst_q;
            r2_q <= r1_q;
            r3_q <= r2_q;
            if (r3_q && !r2_q) begin
                tmo_q <= clk_opt ? CW'(TMO_LONG_CYC) : CW'(TMO_SHORT_CYC);
            end else if (tmo_q != '0) begin
                tmo_q <= tmo_q - CW'(1);
            end
        end
    end

    // Raw bit joins in so reset does not wait for the synchroniser
    assign core_rst_n = !(rst_q || r2_q || r3_q || (tmo_q != '0));
    assign prog_enabled = e2_q;
    assign cmd_stb = cmd_stb_q;
    assign cmd_word = cmd_word_q;
    assign rd_req = rd_req_q;
    assign rd_addr = rd_addr_q;
    assign rd_hi = rd_hi_q;
endmodule : jpd_dev
`default_nettype wire

// >>> design/jpd_host.sv
`include "jpd_params.svh"
`default_nettype none
module jpd_host #(
    parameter int TCK_HALF = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    jpd_link_if.host lnk,
    input wire logic op_valid,
    output logic op_ready,
    input wire jpd_pkg::jpd_op_t op_code,
    input wire logic [`JPD_CMD_W-1:0] op_data,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic busy
);
    import jpd_pkg::*;

    function automatic jpd_scan_t mk(logic is_ir, logic [4:0] len, logic [15:0] data, logic last, logic rsp);
        jpd_scan_t s;
        s.is_ir = is_ir;
        s.len = len;
        s.data = data;
        s.last = last;
        s.rsp = rsp;
        return s;
    endfunction : mk

    function automatic jpd_scan_t ir(logic [`JPD_IR_W-1:0] code);
        return mk(1'b1, `JPD_LEN_IR, {12'h000, code}, 1'b0, 1'b0);
    endfunction : ir

    function automatic jpd_scan_t scan_of(jpd_op_t op, logic [2:0] idx, logic [`JPD_CMD_W-1:0] d);
        jpd_scan_t s;
        s = '0;
        case (op)
            OP_ENTER: begin
                case (idx)
                    3'h0: s = ir(`JPD_IR_CORE_RESET);
                    3'h1: s = mk(1'b0, `JPD_LEN_RST, 16'h0001, 1'b0, 1'b0);
                    3'h2: s = ir(`JPD_IR_KEY);
                    default: s = mk(1'b0, `JPD_LEN_KEY, `JPD_KEY_VALUE, 1'b1, 1'b0);
                endcase
            end
            OP_LEAVE: begin
                case (idx)
                    3'h0: s = ir(`JPD_IR_CMD);
                    3'h1: s = mk(1'b0, `JPD_LEN_CMD, {1'b0, `JPD_NOP_CMD}, 1'b0, 1'b0);
                    3'h2: s = ir(`JPD_IR_KEY);
                    3'h3: s = mk(1'b0, `JPD_LEN_KEY, `JPD_KEY_RESET, 1'b0, 1'b0);
                    3'h4: s = ir(`JPD_IR_CORE_RESET);
                    default: s = mk(1'b0, `JPD_LEN_RST, 16'h0000, 1'b1, 1'b0);
                endcase
            end
            OP_CMD: begin
                s = (idx == 3'h0) ? ir(`JPD_IR_CMD) : mk(1'b0, `JPD_LEN_CMD, {1'b0, d}, 1'b1, 1'b1);
            end
            default: begin
                s = (idx == 3'h0) ? ir(`JPD_IR_PAGE_READ) : mk(1'b0, `JPD_LEN_BYTE, 16'h0000, 1'b1, 1'b1);
            end
        endcase
        return s;
    endfunction : scan_of

    logic run_q;
    jpd_op_t op_q;
    logic [`JPD_CMD_W-1:0] dat_q;
    logic [2:0] idx_q;
    logic [4:0] k_q;
    logic [$clog2(TCK_HALF+1)-1:0] div_q;
    logic tck_q, tms_q, tdi_q;
    logic tdo1_q, tdo2_q;
    logic [15:0] cap_q;
    logic rsp_valid_q;
    logic [15:0] rsp_data_q;

    wire jpd_scan_t cur = scan_of(op_q, idx_q, dat_q);
    wire [4:0] hdr = cur.is_ir ? `JPD_HDR_IR : `JPD_HDR_DR;
    wire [4:0] send = hdr + cur.len;
    // Short scans idle out the gap between Update-DR states
    wire [4:0] total = (send + 5'h02 < `JPD_MIN_SCAN) ? `JPD_MIN_SCAN : send + 5'h02;
    wire [4:0] kn = k_q + 5'h01;
    wire in_shift = (k_q >= hdr) && (k_q < send);
    wire nx_shift = (kn >= hdr) && (kn < send);
    wire nx_tms = (kn < hdr) ? (kn == 5'h00 || (cur.is_ir && kn == 5'h01))
                             : (kn == send - 5'h01 || kn == send);
    wire nx_tdi = nx_shift ? cur.data[4'(kn - hdr)] : 1'b0;
    wire tick = run_q && (div_q == ($bits(div_q))'(TCK_HALF - 1));
    wire fall = tick && tck_q;
    wire start = op_valid && !run_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tdo1_q <= 1'b0;
            tdo2_q <= 1'b0;
            div_q <= '0;
            tck_q <= 1'b0;
        end else begin
            tdo1_q <= lnk.tdo;
            tdo2_q <= tdo1_q;
            div_q <= (tick || !run_q) ? '0 : div_q + 1'b1;
            tck_q <= tick ? !tck_q : tck_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 1'b0;
            op_q <= OP_ENTER;
            dat_q <= `JPD_NOP_CMD;
            idx_q <= 3'h0;
            k_q <= 5'h00;
            tms_q <= 1'b0;
            tdi_q <= 1'b0;
            cap_q <= 16'h0000;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            rsp_valid_q <= 1'b0;
            if (start) begin
                run_q <= 1'b1;
                op_q <= op_code;
                dat_q <= op_data;
                idx_q <= 3'h0;
                k_q <= 5'h00;
                tms_q <= 1'b1;
                tdi_q <= 1'b0;
                cap_q <= 16'h0000;
            end else if (fall) begin
                if (in_shift) begin
                    cap_q[4'(k_q - hdr)] <= tdo2_q;
                end
                if (k_q == total - 5'h01) begin
                    k_q <= 5'h00;
                    tms_q <= !cur.last;
                    tdi_q <= 1'b0;
                    if (cur.last) begin
                        run_q <= 1'b0;
                        rsp_valid_q <= cur.rsp;
                        rsp_data_q <= cur.rsp ? cap_q : rsp_data_q;
                    end else begin
                        idx_q <= idx_q + 3'h1;
                    end
                end else begin
                    k_q <= kn;
                    tms_q <= nx_tms;
                    tdi_q <= nx_tdi;
                end
            end
        end
    end

    assign lnk.tck = tck_q;
    assign lnk.tms = tms_q;
    assign lnk.tdi = tdi_q;
    assign op_ready = !run_q;
    assign busy = run_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
endmodule : jpd_host
`default_nettype wire

// >>> design/jpd_link_if.sv
`default_nettype none
interface jpd_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    modport dev (
        input tck,
        input tms,
        input tdi,
        output tdo,
        output tdo_oe
    );

    modport host (
        output tck,
        output tms,
        output tdi,
        input tdo
    );
endinterface : jpd_link_if
`default_nettype wire

// >>> design/jpd_params.svh
`ifndef JPD_PARAMS_SVH
`define JPD_PARAMS_SVH

// Instruction register
`define JPD_IR_W 4
`define JPD_IR_CORE_RESET 4'hc
`define JPD_IR_KEY 4'h4
`define JPD_IR_CMD 4'h5
`define JPD_IR_PAGE_READ 4'h6
`define JPD_IR_BYPASS 4'hf
`define JPD_IR_CAPTURE 4'h1

// Data register widths and values
`define JPD_KEY_W 16
`define JPD_CMD_W 15
`define JPD_BYTE_W 8
`define JPD_KEY_VALUE 16'ha370
`define JPD_KEY_RESET 16'h0000
`define JPD_NOP_CMD 15'h0000
`define JPD_OP_LSB 8
`define JPD_OP_ADDR_LO 7'h03
`define JPD_OP_ADDR_HI 7'h07

// Scan lengths and spacing in link clock cycles
`define JPD_LEN_RST 5'h01
`define JPD_LEN_IR 5'h04
`define JPD_LEN_KEY 5'h10
`define JPD_LEN_CMD 5'h0f
`define JPD_LEN_BYTE 5'h08
`define JPD_HDR_IR 5'h04
`define JPD_HDR_DR 5'h03
`define JPD_MIN_SCAN 5'h0c

// Reset time-out after the core reset bit is released
`define JPD_MCLK_PERIOD_NS 5
`define JPD_TMO_SHORT_NS 320
`define JPD_TMO_LONG_NS 65000

`endif

// >>> design/jpd_pkg.sv
`default_nettype none
package jpd_pkg;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4,
        TAP_EXIT1_DR = 4'h5,
        TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SHIFT_IR = 4'hb,
        TAP_EXIT1_IR = 4'hc,
        TAP_PAUSE_IR = 4'hd,
        TAP_EXIT2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } jpd_tap_t;

    typedef enum logic [1:0] {
        OP_ENTER = 2'b00,
        OP_LEAVE = 2'b01,
        OP_CMD = 2'b10,
        OP_READ = 2'b11
    } jpd_op_t;

    typedef struct packed {
        logic is_ir;
        logic [4:0] len;
        logic [15:0] data;
        logic last;
        logic rsp;
    } jpd_scan_t;

endpackage : jpd_pkg
`default_nettype wire

// >>> design/jpd_tap.sv
`default_nettype none
module jpd_tap (
    input wire logic tck,
    input wire logic nrst,
    input wire logic tms,
    output jpd_pkg::jpd_tap_t state
);
    import jpd_pkg::*;

    jpd_tap_t state_q;
    jpd_tap_t state_d;

    always_comb begin
        case (state_q)
            TAP_TLR: state_d = tms ? TAP_TLR : TAP_IDLE;
            TAP_IDLE: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_d = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_d = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_d = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_d = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_d = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
            default: state_d = TAP_TLR;
        endcase
    end

    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            state_q <= TAP_TLR;
        end else begin
            state_q <= state_d;
        end
    end

    assign state = state_q;
endmodule : jpd_tap
`default_nettype wire

// >>> testbench/jpd_checker.sv
`include "jpd_params.svh"
`default_nettype none
module jpd_checker #(
    parameter int TMO_SHORT_CYC = 64
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic busy,
    input wire logic rsp_valid,
    input wire logic core_rst_n,
    input wire logic prog_enabled,
    input wire logic cmd_stb,
    input wire logic [`JPD_CMD_W-1:0] cmd_word,
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic rd_hi
);
    timeunit 1ns;
    timeprecision 100ps;
    import jpd_pkg::*;
    logic [15:0] pc_q, lst_addr_q;
    logic lst_hi_q, lst_v_q, first_v_q;
    logic [16:0] low_cnt_q;
    wire load_lo = cmd_stb && cmd_word[14:8] == `JPD_OP_ADDR_LO;
    wire load_hi = cmd_stb && cmd_word[14:8] == `JPD_OP_ADDR_HI;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= 16'h0000;
            lst_addr_q <= 16'h0000;
            lst_hi_q <= 1'b0;
            lst_v_q <= 1'b0;
            first_v_q <= 1'b0;
            low_cnt_q <= 17'h0_0000;
        end else begin
            low_cnt_q <= core_rst_n ? 17'h0_0000 : low_cnt_q + 17'h0_0001;
            if (load_lo) pc_q[7:0] <= cmd_word[7:0];
            if (load_hi) pc_q[15:8] <= cmd_word[7:0];
            first_v_q <= (load_lo || load_hi) || (first_v_q && !rd_req);
            lst_v_q <= !(load_lo || load_hi) && (lst_v_q || rd_req);
            if (rd_req) begin
                lst_addr_q <= rd_addr;
                lst_hi_q <= rd_hi;
            end
        end
    end

    // Either shift state is only reached with mode select low on the edge before
    oe_shift_a: assert property (@(posedge tck) disable iff (!nrst) tdo_oe |-> !$past(tms) && busy)
        else $error("tdo enabled outside a shift state");
    oe_idle_a: assert property (@(posedge mclk) disable iff (!nrst) !busy |-> !tdo_oe)
        else $error("tdo enabled while link idle");
    cmd_gated_a: assert property (@(posedge mclk) disable iff (!nrst) cmd_stb |-> prog_enabled)
        else $error("command accepted without key");
    rd_gated_a: assert property (@(posedge mclk) disable iff (!nrst) rd_req |-> prog_enabled)
        else $error("page fetch without key");
    stb_pulse_a: assert property (@(posedge mclk) disable iff (!nrst) cmd_stb |=> !cmd_stb)
        else $error("command strobe longer than one cycle");
    rd_order_a: assert property (@(posedge mclk) disable iff (!nrst) rd_req && lst_v_q |->
        (rd_addr == lst_addr_q && rd_hi == lst_hi_q) || (lst_hi_q ? (rd_addr == lst_addr_q + 16'h0001 && !rd_hi)
        : (rd_addr == lst_addr_q && rd_hi)))
        else $error("page fetch out of order");
    rd_first_a: assert property (@(posedge mclk) disable iff (!nrst) rd_req && first_v_q |->
        rd_addr == pc_q && !rd_hi)
        else $error("first fetch not at loaded address");
    tmo_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(core_rst_n) |-> low_cnt_q >= TMO_SHORT_CYC)
        else $error("core reset released too early");
    tck_idle_a: assert property (@(posedge mclk) disable iff (!nrst) !busy |-> !tck)
        else $error("link clock runs while idle");
    rsp_pulse_a: assert property (@(posedge mclk) disable iff (!nrst) rsp_valid |-> !busy ##1 !rsp_valid)
        else $error("response pulse malformed");

    cover property (@(posedge mclk) disable iff (!nrst) rd_req && rd_hi && rd_addr[6:0] == 7'h7f);
    cover property (@(posedge mclk) disable iff (!nrst) cmd_stb && prog_enabled);
    cover property (@(posedge mclk) disable iff (!nrst) $rose(core_rst_n));
    cover property (@(posedge tck) disable iff (!nrst) tdo_oe && tdo && tdi);
endmodule : jpd_checker
`default_nettype wire

// >>> testbench/test_jtag_programming_data_registers.sv
`include "jpd_params.svh"
`default_nettype none
module test_jtag_programming_data_registers;
    timeunit 1ns;
    timeprecision 100ps;
    import jpd_pkg::*;
    localparam int TMO_S = 100;
    logic mclk = 1'b0, nrst = 1'b0, clk_opt = 1'b0, op_valid = 1'b0, res_valid = 1'b0, rd_ack = 1'b0;
    jpd_op_t op_code = OP_ENTER;
    logic [14:0] op_data = 15'h0000, res_data = 15'h0000, cmd_word, last_cmd;
    logic [7:0] rd_data = 8'h00;
    logic op_ready, rsp_valid, busy, core_rst_n, prog_enabled, cmd_stb, rd_req, rd_hi;
    logic [15:0] rsp_data, rd_addr, rsp, exp_a;
    int n_fail = 0, checked = 0, n_stb = 0;

    jpd_link_if lnk ();
    jpd_host #(.TCK_HALF(4)) jpd_host_i (.mclk(mclk), .nrst(nrst), .lnk(lnk), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .op_data(op_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .busy(busy));
    jpd_dev #(.TMO_SHORT_CYC(TMO_S), .TMO_LONG_CYC(200)) jpd_dev_i (.lnk(lnk), .mclk(mclk), .nrst(nrst),
        .clk_opt(clk_opt), .core_rst_n(core_rst_n), .prog_enabled(prog_enabled), .cmd_stb(cmd_stb),
        .cmd_word(cmd_word), .res_valid(res_valid), .res_data(res_data), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_hi(rd_hi), .rd_ack(rd_ack), .rd_data(rd_data));
    jpd_checker #(.TMO_SHORT_CYC(TMO_S)) jpd_checker_i (.mclk(mclk), .nrst(nrst), .tck(lnk.tck),
        .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .tdo_oe(lnk.tdo_oe), .busy(busy),
        .rsp_valid(rsp_valid), .core_rst_n(core_rst_n), .prog_enabled(prog_enabled),
        .cmd_stb(cmd_stb), .cmd_word(cmd_word), .rd_req(rd_req), .rd_addr(rd_addr), .rd_hi(rd_hi));

    always #2.5 mclk = ~mclk;

    // Core-side result and memory stand-ins, answering one cycle after each request
    always @(negedge mclk) begin
        res_valid <= cmd_stb;
        res_data <= cmd_word ^ 15'h5555;
        rd_ack <= rd_req;
        rd_data <= {rd_addr[6:0], rd_hi};
        if (cmd_stb === 1'b1) begin
            n_stb++;
            last_cmd = cmd_word;
        end
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task run_op(input jpd_op_t code, input logic [14:0] data);
        int i;
        @(negedge mclk);
        op_valid = 1'b1;
        op_code = code;
        op_data = data;
        @(negedge mclk);
        op_valid = 1'b0;
        check({15'h0000, op_ready}, 16'h0000);
        i = 0;
        while (busy === 1'b1 && i < 4000) begin
            @(negedge mclk);
            if (rsp_valid === 1'b1) rsp = rsp_data;
            i++;
        end
        check({15'h0000, busy}, 16'h0000);
    endtask : run_op

    // Released bit was shifted before busy falls, so only the tail of the time-out is seen here
    task leave_check(input int lo, input int hi);
        int n;
        run_op(OP_LEAVE, 15'h0000);
        n = 0;
        while (core_rst_n !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        checked++;
        if (n < lo || n > hi) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, n, hi);
        end
        check({15'h0000, prog_enabled}, 16'h0000);
    endtask : leave_check

    task conclude;
        $display("Counts: %0d failed, %0d checked", n_fail, checked);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    initial begin
        #400000;
        n_fail++;
        $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        conclude();
    end

    initial begin
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        check({15'h0000, core_rst_n}, 16'h0001);
        check({15'h0000, prog_enabled}, 16'h0000);
        run_op(OP_CMD, 15'h0312);
        check(16'(n_stb), 16'h0000);
        // First scan after reset may start from Test-Logic-Reset, so enter twice
        run_op(OP_ENTER, 15'h0000);
        run_op(OP_ENTER, 15'h0000);
        repeat (4) @(negedge mclk);
        check({15'h0000, core_rst_n}, 16'h0000);
        check({15'h0000, prog_enabled}, 16'h0001);
        run_op(OP_CMD, {`JPD_OP_ADDR_LO, 8'hfe});
        check(rsp, 16'h0000);
        run_op(OP_CMD, {`JPD_OP_ADDR_HI, 8'h12});
        check(rsp, {1'b0, {`JPD_OP_ADDR_LO, 8'hfe} ^ 15'h5555});
        check({1'b0, last_cmd}, {1'b0, `JPD_OP_ADDR_HI, 8'h12});
        for (int k = 0; k < 6; k++) begin
            run_op(OP_READ, 15'h0000);
            exp_a = 16'h12fe + 16'(k / 2);
            check({8'h00, rsp[7:0]}, {8'h00, exp_a[6:0], k[0]});
        end
        leave_check(TMO_S - 70, TMO_S - 60);
        clk_opt = 1'b1;
        run_op(OP_ENTER, 15'h0000);
        leave_check(130, 140);
        run_op(OP_CMD, 15'h0312);
        check(16'(n_stb), 16'h0004);
        conclude();
    end
endmodule : test_jtag_programming_data_registers
`default_nettype wire
